// ==== rtl/rst_ctrl_pkg.sv ====
// Constants, encodings and register map of the reset sequencing block.
// Assumes a single 25 MHz clock; every other time is counted in cycles or ticks.
package rst_ctrl_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int RESET_HOLD_DELAY_NS = 100_000_000;  // typical reset hold delay
    localparam int RESET_HOLD_CYCLES = RESET_HOLD_DELAY_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 22;
    // Start-up timer targets, in ticks of the selected system clock
    localparam logic [CNT_W-1:0] SST_RC_TICKS = 22'h000010;
    localparam logic [CNT_W-1:0] SST_XTAL_TICKS = 22'h000400;
    localparam logic [CNT_W-1:0] SST_SLOW_RC_TICKS = 22'h000002;

    // ----------------------------------------------------------------
    // Encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_HOLD = 2'h0,
        ST_DELAY = 2'h1,
        ST_STARTUP = 2'h2,
        ST_RUN = 2'h3
    } seq_st_t;

    typedef enum logic [2:0] {
        RT_NONE = 3'h0,
        RT_POWER_ON = 3'h1,
        RT_PIN_LVR = 3'h2,
        RT_WDT_NORMAL = 3'h3,
        RT_WDT_IDLE = 3'h4
    } reset_type_t;

    localparam logic [2:0] OSC_EXTERNAL_RC = 3'h0;
    localparam logic [2:0] OSC_INTERNAL_FAST_RC = 3'h1;
    localparam logic [2:0] OSC_FAST_CRYSTAL = 3'h2;
    localparam logic [2:0] OSC_SLOW_CRYSTAL = 3'h3;
    localparam logic [2:0] OSC_INTERNAL_SLOW_RC = 3'h4;

    // ----------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] REG_STATUS = 12'h000;
    localparam logic [ADDR_W-1:0] REG_CLKSEL = 12'h004;
    localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 12'h008;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 12'h00C;
    localparam int STAT_WTO_BIT = 0;
    localparam int STAT_PDF_BIT = 1;
    localparam int STAT_TYPE_LSB = 2;
    localparam int STAT_HOLD_BIT = 5;
    localparam int EV_PIN_LVR = 0;
    localparam int EV_WDT_NORMAL = 1;
    localparam int EV_WDT_IDLE = 2;
    localparam int EV_STARTUP_DONE = 3;
    localparam int EV_W = 4;
    localparam logic [2:0] CLKSEL_RESET = 3'h1;
    localparam logic [EV_W-1:0] IRQ_MASK_RESET = 4'h0;

endpackage : rst_ctrl_pkg

// ==== rtl/reset_source_state_control.sv ====
// Reset source arbitration, flag handling and start-up sequencing.
// Assumes NRST_I is the power-on reset, all other inputs synchronous to MCLK_I,
// SYS_TICK_I one-cycle pulses at edges of the selected system clock.
// Notes on behaviour
// [R1] Normal watchdog timeout: pin-type reset, timeout flag set
// [R2] Idle watchdog timeout: clear PC, SP, set flag
// [R3] External/fast internal RC: start-up 15 to 16 ticks
// [R4] Crystal sources: start-up counts 1024 ticks
// [R5] Slow internal RC: start-up 1 to 2 ticks
// [R6] Full resets hold execution for reset delay
// [R7] Power-on clears timeout and power-down flags
// [R8] Pin or low-voltage reset leaves flags unchanged
// [R9] Idle watchdog reset sets both flags
// [R10] Power-on disables every interrupt source
// [R11] Power-on clears watchdog, then it counts
// [R12] Power-on switches all timers off
// [R13] Power-on: ports inputs, analogue pins converter inputs
// [R14] Power-on sets stack pointer to top
// [R15] Distinct reset values for four reset types
// [R16] Every reset clears the program counter
// [R17] Outside party holds pin low to reset
// [R18] Priority: power-on, then pin/low-voltage, then watchdog
// [R19] Start-up counts selected clock, releases at target
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module reset_source_state_control #(
    parameter int RESET_HOLD_CYCLES = rst_ctrl_pkg::RESET_HOLD_CYCLES
) (
    input wire logic MCLK_I,
    input wire logic NRST_I,
    input wire logic EXT_RESET_PIN_N_I,
    input wire logic LOW_VOLTAGE_RESET_I,
    input wire logic WDT_TIMEOUT_I,
    input wire logic LOW_POWER_MODE_I,
    input wire logic SLEEP_ENTER_I,
    input wire logic SYS_TICK_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [rst_ctrl_pkg::ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic CORE_HOLD_O,
    output logic PC_CLEAR_O,
    output logic SP_CLEAR_O,
    output logic SP_TOP_O,
    output logic FULL_RESET_O,
    output logic INT_DISABLE_O,
    output logic WDT_CLEAR_O,
    output logic TIMERS_OFF_O,
    output logic PORTS_INPUT_O,
    output logic ANALOG_SEL_O,
    output logic [2:0] RESET_TYPE_O,
    output logic WDT_TIMEOUT_FLAG_O,
    output logic POWER_DOWN_FLAG_O,
    output logic IRQ_O
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        rst_ctrl_pkg::seq_st_t st;
        rst_ctrl_pkg::reset_type_t rtype;
        logic [rst_ctrl_pkg::CNT_W-1:0] cnt;
        logic wto;
        logic power_down_flag;
        logic [2:0] clksel;
        logic [rst_ctrl_pkg::EV_W-1:0] ev;
        logic [rst_ctrl_pkg::EV_W-1:0] mask;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic hold;
        logic full;
        logic spclr;
        logic irq;
    } state_t;

    state_t q;
    state_t d;
    logic pin_req;
    logic wdt_req;
    logic apb_done;
    logic [rst_ctrl_pkg::CNT_W-1:0] sst_target;
    logic [rst_ctrl_pkg::CNT_W-1:0] hold_last;

    assign hold_last = rst_ctrl_pkg::CNT_W'(RESET_HOLD_CYCLES - 1);

    // Reset requests, pin and low-voltage outrank the watchdog
    assign pin_req = !EXT_RESET_PIN_N_I || LOW_VOLTAGE_RESET_I;  // see [R17]
    assign wdt_req = WDT_TIMEOUT_I && (q.st == rst_ctrl_pkg::ST_RUN) && !pin_req;  // see [R18]
    assign apb_done = PSEL_I && PENABLE_I && q.pready;

    // Start-up target follows the oscillator in use
    always_comb
    begin
        case (q.clksel)
            rst_ctrl_pkg::OSC_EXTERNAL_RC,
            rst_ctrl_pkg::OSC_INTERNAL_FAST_RC: sst_target = rst_ctrl_pkg::SST_RC_TICKS;  // see [R3]
            rst_ctrl_pkg::OSC_INTERNAL_SLOW_RC:
                sst_target = rst_ctrl_pkg::SST_SLOW_RC_TICKS;  // see [R5]
            default: sst_target = rst_ctrl_pkg::SST_XTAL_TICKS;  // see [R4]
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.pready = 1'b0;
        d.pslverr = 1'b0;

        // Register access: software clears first so a same-cycle set wins
        if (apb_done && PWRITE_I)
        begin
            case (PADDR_I)
                rst_ctrl_pkg::REG_STATUS:
                begin
                    if (PWDATA_I[rst_ctrl_pkg::STAT_WTO_BIT])
                        d.wto = 1'b0;
                    if (PWDATA_I[rst_ctrl_pkg::STAT_PDF_BIT])
                        d.power_down_flag = 1'b0;
                end
                rst_ctrl_pkg::REG_CLKSEL: d.clksel = PWDATA_I[2:0];
                rst_ctrl_pkg::REG_IRQ_MASK: d.mask = PWDATA_I[rst_ctrl_pkg::EV_W-1:0];
                default: d.clksel = q.clksel;
            endcase
        end
        // Read clears only the bits that were returned, so a late event survives
        if (apb_done && !PWRITE_I && (PADDR_I == rst_ctrl_pkg::REG_IRQ_STATUS))
            d.ev = q.ev & ~q.prdata[rst_ctrl_pkg::EV_W-1:0];

        // Reset sequencer
        if (pin_req)
        begin
            d.st = rst_ctrl_pkg::ST_HOLD;
            // A pending power-on sequence keeps its type until it completes
            if (q.rtype != rst_ctrl_pkg::RT_POWER_ON || q.st == rst_ctrl_pkg::ST_RUN)
                d.rtype = rst_ctrl_pkg::RT_PIN_LVR;  // see [R18]
            d.cnt = '0;
            if (q.st == rst_ctrl_pkg::ST_RUN)
                d.ev[rst_ctrl_pkg::EV_PIN_LVR] = 1'b1;
            // Flags are left alone here, see [R8]
        end
        else
        begin
            case (q.st)
                rst_ctrl_pkg::ST_HOLD:
                begin
                    d.st = rst_ctrl_pkg::ST_DELAY;
                    d.cnt = '0;
                end
                rst_ctrl_pkg::ST_DELAY:
                begin
                    d.cnt = q.cnt + 1'b1;
                    if (q.cnt >= hold_last)  // see [R6]
                    begin
                        d.st = rst_ctrl_pkg::ST_STARTUP;
                        d.cnt = '0;
                    end
                end
                rst_ctrl_pkg::ST_STARTUP:
                begin
                    // Count only edges of the selected source, see [R19]
                    if (SYS_TICK_I)
                    begin
                        d.cnt = q.cnt + 1'b1;
                        if (q.cnt + 1'b1 >= sst_target)
                        begin
                            d.st = rst_ctrl_pkg::ST_RUN;
                            d.cnt = '0;
                            d.ev[rst_ctrl_pkg::EV_STARTUP_DONE] = 1'b1;
                        end
                    end
                end
                rst_ctrl_pkg::ST_RUN:
                begin
                    if (wdt_req && LOW_POWER_MODE_I)
                    begin
                        // Wake path: only PC and SP are cleared, see [R2]
                        d.st = rst_ctrl_pkg::ST_STARTUP;
                        d.rtype = rst_ctrl_pkg::RT_WDT_IDLE;
                        d.cnt = '0;
                        d.wto = 1'b1;  // see [R9]
                        d.power_down_flag = 1'b1;  // see [R9]
                        d.ev[rst_ctrl_pkg::EV_WDT_IDLE] = 1'b1;
                    end
                    else if (wdt_req)
                    begin
                        // Like a pin reset, but straight into the delay, with its own reset type and the flag set, see [R1]
                        d.st = rst_ctrl_pkg::ST_DELAY;
                        d.rtype = rst_ctrl_pkg::RT_WDT_NORMAL;
                        d.cnt = '0;
                        d.wto = 1'b1;
                        d.ev[rst_ctrl_pkg::EV_WDT_NORMAL] = 1'b1;
                    end
                    else if (SLEEP_ENTER_I)
                        d.power_down_flag = 1'b1;
                end
                default: d.st = rst_ctrl_pkg::ST_HOLD;
            endcase
        end

        // APB setup phase: capture read data, answer in the access phase
        if (PSEL_I && !PENABLE_I)
        begin
            d.pready = 1'b1;
            d.prdata = '0;
            case (PADDR_I)
                rst_ctrl_pkg::REG_STATUS:
                begin
                    d.prdata[rst_ctrl_pkg::STAT_WTO_BIT] = q.wto;
                    d.prdata[rst_ctrl_pkg::STAT_PDF_BIT] = q.power_down_flag;
                    d.prdata[rst_ctrl_pkg::STAT_TYPE_LSB +: 3] = q.rtype;
                    d.prdata[rst_ctrl_pkg::STAT_HOLD_BIT] = q.hold;
                end
                rst_ctrl_pkg::REG_CLKSEL: d.prdata[2:0] = q.clksel;
                rst_ctrl_pkg::REG_IRQ_STATUS: d.prdata[rst_ctrl_pkg::EV_W-1:0] = q.ev;
                rst_ctrl_pkg::REG_IRQ_MASK: d.prdata[rst_ctrl_pkg::EV_W-1:0] = q.mask;
                default: d.pslverr = 1'b1;
            endcase
        end

        // Registered outputs follow the next sequencer state
        d.hold = (d.st != rst_ctrl_pkg::ST_RUN);  // see [R16]
        d.full = d.hold && (d.rtype != rst_ctrl_pkg::RT_WDT_IDLE);  // see [R15]
        d.spclr = d.hold && (d.rtype == rst_ctrl_pkg::RT_WDT_IDLE);  // see [R2]
        d.irq = |(d.ev & d.mask);
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Power-on: held in reset, both flags cleared, see [R7]
    always_ff @(posedge MCLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            q.st <= rst_ctrl_pkg::ST_HOLD;
            q.rtype <= rst_ctrl_pkg::RT_POWER_ON;
            q.cnt <= '0;
            q.wto <= 1'b0;
            q.power_down_flag <= 1'b0;
            q.clksel <= rst_ctrl_pkg::CLKSEL_RESET;
            q.ev <= '0;
            q.mask <= rst_ctrl_pkg::IRQ_MASK_RESET;
            q.pready <= 1'b0;
            q.pslverr <= 1'b0;
            q.prdata <= '0;
            q.hold <= 1'b1;
            q.full <= 1'b1;
            q.spclr <= 1'b0;
            q.irq <= 1'b0;
        end
        else
            q <= d;
    end

    // Full resets drive every power-on default of the core, see [R10] [R11] [R12] [R13] [R14]
    assign PRDATA_O = q.prdata;
    assign PREADY_O = q.pready;
    assign PSLVERR_O = q.pslverr;
    assign CORE_HOLD_O = q.hold;
    assign PC_CLEAR_O = q.hold;
    assign SP_CLEAR_O = q.spclr;
    assign SP_TOP_O = q.full;
    assign FULL_RESET_O = q.full;
    assign INT_DISABLE_O = q.full;
    assign WDT_CLEAR_O = q.full;  // Counter released the cycle the hold ends
    assign TIMERS_OFF_O = q.full;
    assign PORTS_INPUT_O = q.full;
    assign ANALOG_SEL_O = q.full;
    assign RESET_TYPE_O = q.rtype;
    assign WDT_TIMEOUT_FLAG_O = q.wto;
    assign POWER_DOWN_FLAG_O = q.power_down_flag;
    assign IRQ_O = q.irq;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!NRST_I);

    logic [rst_ctrl_pkg::CNT_W-1:0] h_ticks;
    logic [rst_ctrl_pkg::CNT_W-1:0] h_delay;

    // Independent tick and cycle counters for the timing checks
    always_ff @(posedge MCLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            h_ticks <= '0;
            h_delay <= '0;
        end
        else
        begin
            h_ticks <= (q.st == rst_ctrl_pkg::ST_STARTUP) ? h_ticks + 22'(SYS_TICK_I) : '0;
            h_delay <= (q.st == rst_ctrl_pkg::ST_DELAY) ? h_delay + 1'b1 : '0;
        end
    end

    sequence startup_end_s;
        (q.st == rst_ctrl_pkg::ST_STARTUP) ##1 (q.st == rst_ctrl_pkg::ST_RUN);
    endsequence

    sequence delay_end_s;
        (q.st == rst_ctrl_pkg::ST_DELAY) && !pin_req ##1 (q.st == rst_ctrl_pkg::ST_STARTUP);
    endsequence

    sequence idle_wdt_s;
        wdt_req && LOW_POWER_MODE_I;
    endsequence

    // Watchdog paths: full reset through the delay, idle wake straight to start-up
    wdt_normal_flag_a: assert property (  // see [R1]
        wdt_req && !LOW_POWER_MODE_I |=> WDT_TIMEOUT_FLAG_O
        && RESET_TYPE_O == rst_ctrl_pkg::RT_WDT_NORMAL && FULL_RESET_O)
        else $error("normal watchdog reset wrong");
    wdt_idle_clear_a: assert property (  // see [R2]
        idle_wdt_s |=> SP_CLEAR_O && PC_CLEAR_O && !FULL_RESET_O)
        else $error("idle watchdog reset did not clear PC and SP only");
    idle_flags_set_a: assert property (  // see [R9]
        idle_wdt_s |=> WDT_TIMEOUT_FLAG_O && POWER_DOWN_FLAG_O)
        else $error("idle watchdog reset flags not both set");
    full_delay_a: assert property (  // see [R6]
        wdt_req && !LOW_POWER_MODE_I |=> q.st == rst_ctrl_pkg::ST_DELAY)
        else $error("normal watchdog reset skipped the hold delay");
    idle_no_delay_a: assert property (  // see [R2]
        idle_wdt_s |=> q.st == rst_ctrl_pkg::ST_STARTUP && q.cnt == '0)
        else $error("idle watchdog reset did not go to start-up");

    // Timing: counted independently of the sequencer counter
    startup_ticks_a: assert property (  // see [R19]
        startup_end_s |-> h_ticks == $past(sst_target))
        else $error("start-up ended at wrong tick count");
    startup_short_a: assert property (  // see [R3] [R4] [R5]
        (q.st == rst_ctrl_pkg::ST_STARTUP) |-> h_ticks < sst_target)
        else $error("start-up overran its target");
    delay_length_a: assert property (  // see [R6]
        delay_end_s |-> h_delay == 22'(RESET_HOLD_CYCLES))
        else $error("reset hold delay wrong length");

    // Flags, defaults and priority; power-on checks only while still held
    pin_flags_kept_a: assert property (  // see [R8]
        pin_req |=> WDT_TIMEOUT_FLAG_O == $past(q.wto)
        && POWER_DOWN_FLAG_O == $past(q.power_down_flag))
        else $error("pin reset changed a flag");
    por_flags_zero_a: assert property (  // see [R7]
        (RESET_TYPE_O == rst_ctrl_pkg::RT_POWER_ON) && CORE_HOLD_O
        |-> !WDT_TIMEOUT_FLAG_O && !POWER_DOWN_FLAG_O)
        else $error("power-on flags not zero");
    por_defaults_a: assert property (  // see [R10] [R11] [R12] [R13] [R14]
        (RESET_TYPE_O == rst_ctrl_pkg::RT_POWER_ON) && CORE_HOLD_O
        |-> INT_DISABLE_O && TIMERS_OFF_O && PORTS_INPUT_O && ANALOG_SEL_O
        && SP_TOP_O && WDT_CLEAR_O)
        else $error("power-on defaults not driven");
    pc_clear_hold_a: assert property (  // see [R16]
        (pin_req || wdt_req) |=> PC_CLEAR_O && CORE_HOLD_O)
        else $error("reset request did not clear PC");
    prio_pin_a: assert property (  // see [R18]
        pin_req && WDT_TIMEOUT_I && q.st == rst_ctrl_pkg::ST_RUN
        |=> RESET_TYPE_O == rst_ctrl_pkg::RT_PIN_LVR && CORE_HOLD_O)
        else $error("watchdog outranked pin reset");
    por_type_kept_a: assert property (  // see [R18]
        pin_req && CORE_HOLD_O && RESET_TYPE_O == rst_ctrl_pkg::RT_POWER_ON
        |=> RESET_TYPE_O == rst_ctrl_pkg::RT_POWER_ON)
        else $error("pin reset replaced pending power-on type");
    sleep_pdf_a: assert property (  // see [R7]
        SLEEP_ENTER_I && !pin_req && !wdt_req && q.st == rst_ctrl_pkg::ST_RUN
        |=> POWER_DOWN_FLAG_O)
        else $error("sleep entry did not set power-down flag");

endmodule : reset_source_state_control

// ==== bench/reset_partner_model.sv ====
// Far-side model: external reset pin, supply monitor, watchdog and clock ticks.
// Assumes the bench commands it; every output changes just after MCLK rises.
`timescale 1ns/1ps
module reset_partner_model (
    input wire logic clk_i,
    input wire logic pin_req_i,
    input wire logic lvr_req_i,
    input wire logic wdt_req_i,
    input wire logic tick_en_i,
    output logic pin_n_o,
    output logic lvr_o,
    output logic wdt_o,
    output logic tick_o
);
    logic div_q;

    // Quiet levels at time zero, before the first edge
    initial
    begin
        pin_n_o = 1'b1;
        lvr_o = 1'b0;
        wdt_o = 1'b0;
        tick_o = 1'b0;
        div_q = 1'b0;
    end

    // Pin is held low for the whole request and released high after it
    always @(posedge clk_i)
    begin
        pin_n_o <= !pin_req_i;
        lvr_o <= lvr_req_i;
        wdt_o <= wdt_req_i;
        div_q <= !div_q;
        // Slow source: a tick every second cycle, so counts are not cycle counts
        tick_o <= tick_en_i & div_q;
    end
endmodule : reset_partner_model

// ==== bench/reset_source_state_control_test.sv ====
// Self-checking bench for the reset sequencer, with APB tasks and a far-side model.
// Assumes a 25 MHz clock and a reset hold delay shortened to 8 cycles.
`timescale 1ns/1ps
module reset_source_state_control_test;
    localparam int HOLD = 8;
    logic mclk, nrst_n, lpm, sleep_en, tick_en, pin_req, lvr_req, wdt_req;
    logic pin_n, low_voltage_reset, wdt, tick, psel, penable, pwrite, pready, pslverr, err;
    logic [rst_ctrl_pkg::ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic hold, pc_clr, sp_clr, sp_top, full, int_dis, wdt_clr, tmr_off;
    logic ports_in, ana_sel, wto, power_down_flag, irq;
    logic [2:0] rtype;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    int n, tk;

    reset_partner_model i_far (.clk_i(mclk), .pin_req_i(pin_req), .lvr_req_i(lvr_req),
        .wdt_req_i(wdt_req), .tick_en_i(tick_en), .pin_n_o(pin_n), .lvr_o(low_voltage_reset),
        .wdt_o(wdt), .tick_o(tick));

    reset_source_state_control #(.RESET_HOLD_CYCLES(HOLD)) i_dut (.MCLK_I(mclk),
        .NRST_I(nrst_n), .EXT_RESET_PIN_N_I(pin_n), .LOW_VOLTAGE_RESET_I(low_voltage_reset),
        .WDT_TIMEOUT_I(wdt), .LOW_POWER_MODE_I(lpm), .SLEEP_ENTER_I(sleep_en),
        .SYS_TICK_I(tick), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .CORE_HOLD_O(hold), .PC_CLEAR_O(pc_clr),
        .SP_CLEAR_O(sp_clr), .SP_TOP_O(sp_top), .FULL_RESET_O(full),
        .INT_DISABLE_O(int_dis), .WDT_CLEAR_O(wdt_clr), .TIMERS_OFF_O(tmr_off),
        .PORTS_INPUT_O(ports_in), .ANALOG_SEL_O(ana_sel), .RESET_TYPE_O(rtype),
        .WDT_TIMEOUT_FLAG_O(wto), .POWER_DOWN_FLAG_O(power_down_flag), .IRQ_O(irq));

    // ----------------------------------------------------------------
    // Clock, time-zero values and hang guard
    // ----------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = !mclk;
    end

    initial
    begin
        {nrst_n, lpm, sleep_en, pin_req, lvr_req, wdt_req, psel, penable, pwrite} = '0;
        tick_en = 1'b1;
        paddr = '0;
        pwdata = '0;
    end

    // Longest legal run is two crystal start-ups plus short sequences
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            test_done();
        end
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask : chk

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Waits for the hold level, counting cycles and ticks taken while held
    task automatic wait_hold(input logic lvl);
        n = 0;
        tk = 0;
        while (hold !== lvl && n < 5000)
        begin
            @(posedge mclk);
            if (tick === 1'b1 && hold === 1'b1)
                tk++;
            #1;
            n++;
        end
        // Running out of the limit is a failure, not a silent pass
        if (hold !== lvl)
        begin
            $display("CHECK FAILED hold level expected %b seen %b", lvl, hold);
            n_fail++;
        end
    endtask : wait_hold

    task automatic fire_wdt();
        @(posedge mclk);
        wdt_req <= 1'b1;
        @(posedge mclk);
        wdt_req <= 1'b0;
        wait_hold(1'b1);
    endtask : fire_wdt

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_power_on();
        repeat (12) @(posedge mclk);
        chk("pon outputs", 9'h1FF, {hold, pc_clr, full, sp_top, int_dis, wdt_clr,
            tmr_off, ports_in, ana_sel});
        chk("pon flags", 5'h01, {sp_clr, wto, power_down_flag, rtype[1:0]});
        nrst_n <= 1'b1;
        wait_hold(1'b0);
        chk("pon delay", 1, n > HOLD + 2);
        apb(1'b0, rst_ctrl_pkg::REG_STATUS, '0);
        chk("pon status", 32'h4, rd);
        apb(1'b0, rst_ctrl_pkg::REG_IRQ_MASK, '0);
        chk("mask reset", 32'h0, rd);
        $display("test power_on done");
    endtask : t_power_on

    task automatic t_wdt_normal();
        @(posedge mclk);
        sleep_en <= 1'b1;
        @(posedge mclk);
        sleep_en <= 1'b0;
        apb(1'b1, rst_ctrl_pkg::REG_IRQ_MASK, 32'h2);
        chk("pdf set", 1'b1, power_down_flag);
        fire_wdt();
        chk("wdt normal", 6'h2F, {full, sp_clr, wto, power_down_flag, rtype[1:0]});
        wait_hold(1'b0);
        chk("wdt delay", 1, n > HOLD);
        chk("irq up", 1'b1, irq);
        apb(1'b0, rst_ctrl_pkg::REG_IRQ_STATUS, '0);
        chk("irq status", 32'hA, rd);
        repeat (2) @(posedge mclk);
        chk("irq cleared", 1'b0, irq);
        $display("test wdt_normal done");
    endtask : t_wdt_normal

    task automatic t_pin_lvr();
        @(posedge mclk);
        pin_req <= 1'b1;
        wdt_req <= 1'b1;
        @(posedge mclk);
        wdt_req <= 1'b0;
        wait_hold(1'b1);
        chk("pin type", 6'h3A, {pc_clr, wto, power_down_flag, rtype});
        repeat (3) @(posedge mclk);
        pin_req <= 1'b0;
        wait_hold(1'b0);
        apb(1'b1, rst_ctrl_pkg::REG_STATUS, 32'h3);
        @(posedge mclk);
        lvr_req <= 1'b1;
        @(posedge mclk);
        lvr_req <= 1'b0;
        wait_hold(1'b1);
        chk("lvr flags", 5'h02, {wto, power_down_flag, rtype});
        wait_hold(1'b0);
        apb(1'b0, 12'h010, '0);
        chk("unmapped error", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        $display("test pin_lvr done");
    endtask : t_pin_lvr

    task automatic t_idle_startup();
        int tgt[5] = '{16, 16, 1024, 1024, 2};
        for (int s = 0; s < 5; s++)
        begin
            apb(1'b1, rst_ctrl_pkg::REG_CLKSEL, 32'(s));
            lpm <= 1'b1;
            fire_wdt();
            chk("idle wdt", 8'hDC, {pc_clr, sp_clr, full, wto, power_down_flag, rtype});
            wait_hold(1'b0);
            chk("startup ticks", tgt[s], tk);
            lpm <= 1'b0;
        end
        $display("test idle_startup done");
    endtask : t_idle_startup

    // Power-on mid-run clears flags left set, and a pin request leaves the power-on type in place
    task automatic t_por_again();
        @(posedge mclk);
        nrst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("por flags", 6'h01, {sp_clr, wto, power_down_flag, rtype});
        chk("por outputs", 3'h7, {hold, full, int_dis});
        nrst_n <= 1'b1;
        pin_req <= 1'b1;
        repeat (4) @(posedge mclk);
        pin_req <= 1'b0;
        chk("por type kept", 3'h1, rtype);
        wait_hold(1'b0);
        apb(1'b0, rst_ctrl_pkg::REG_CLKSEL, '0);
        chk("clksel reset", 32'h1, rd);
        $display("test por_again done");
    endtask : t_por_again

    task automatic test_done();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done

    initial
    begin
        t_power_on();
        t_wdt_normal();
        t_pin_lvr();
        t_idle_startup();
        t_por_again();
        test_done();
    end
endmodule : reset_source_state_control_test
